// ---- rtl/asq_pkg.sv ----
package asq_pkg;

    // Clock rates and the converter clock divider.
    localparam int SYS_CLK_MHZ = 200;
    localparam int CONV_CLK_MHZ = 25;
    localparam int HALF_DIV = SYS_CLK_MHZ / (2 * CONV_CLK_MHZ);

    // Converter core geometry.
    localparam int RES_W = 12;
    localparam int NUM_CH = 16;
    localparam int CH_W = 4;
    localparam int PIPE_STAGES = 4;

    // Sequence timing in converter half periods.
    localparam logic [5:0] TRIG_HALVES = 6'h05;
    localparam logic [5:0] SEQ_GAP_HALVES = 6'h02;
    localparam logic [5:0] SIM_GAP_HALVES = 6'h04;
    localparam logic [5:0] SH_BASE_HALVES = 6'h02;

    // Register offsets (byte addresses).
    localparam logic [7:0] CTRL1_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] MASK_OFS = 8'h0c;
    localparam logic [7:0] RES_BASE = 8'h40;

    // Field positions of converter_control_one.
    localparam int MODE_BIT = 0;
    localparam int CONT_BIT = 1;
    localparam int ACQ_LSB = 8;
    localparam int ACQ_W = 4;
    localparam int CHAN_LSB = 16;
    localparam int TEN_LSB = 20;
    localparam logic [31:0] CTRL1_MASK = 32'h007f_0f03;
    localparam logic [31:0] CTRL1_RST = 32'h0000_0000;

    // Command, status and mask fields.
    localparam int CMD_START_BIT = 0;
    localparam int CMD_STOP_BIT = 1;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_DROP_BIT = 1;
    localparam int STAT_BUSY_BIT = 8;
    localparam int INT_W = 2;
    localparam logic [INT_W-1:0] STAT_RST = 2'h0;
    localparam logic [INT_W-1:0] MASK_RST = 2'h0;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_DELAY = 2'b01,
        S_SAMPLE = 2'b11,
        S_GAP = 2'b10
    } asq_state_t;

endpackage

// ---- rtl/asq_pipe_if.sv ----
`timescale 1ns/1ps
interface asq_pipe_if #(
    parameter int W = 12,
    parameter int CW = 4
);
    logic shift;
    logic push_valid;
    logic [W-1:0] push_data;
    logic [CW-1:0] push_chan;
    logic res_valid;
    logic [W-1:0] res_data;
    logic [CW-1:0] res_chan;
    logic busy;

    modport ctl(
        output shift, push_valid, push_data, push_chan,
        input res_valid, res_data, res_chan, busy
    );
    modport core(
        input shift, push_valid, push_data, push_chan,
        output res_valid, res_data, res_chan, busy
    );
endinterface

// ---- rtl/asq_pipe.sv ----
`timescale 1ns/1ps
module asq_pipe import asq_pkg::*; #(
    parameter int STAGES = PIPE_STAGES
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    asq_pipe_if.core p
);
    logic [STAGES-1:0] v_q, v_d;
    logic [RES_W-1:0] d_q [STAGES];
    logic [RES_W-1:0] d_d [STAGES];
    logic [CH_W-1:0] c_q [STAGES];
    logic [CH_W-1:0] c_d [STAGES];

    // A new sample loads stage zero while older ones keep moving.
    always_comb begin
        v_d = v_q;
        d_d = d_q;
        c_d = c_q;
        if (p.shift) begin
            for (int i = 1; i < STAGES; i++) begin
                v_d[i] = v_q[i-1];
                d_d[i] = d_q[i-1];
                c_d[i] = c_q[i-1];
            end
            v_d[0] = 1'b0;
        end
        if (p.push_valid) begin
            v_d[0] = 1'b1;
            d_d[0] = p.push_data;
            c_d[0] = p.push_chan;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            v_q <= '0;
            for (int i = 0; i < STAGES; i++) begin
                d_q[i] <= '0;
                c_q[i] <= '0;
            end
        end else begin
            v_q <= v_d;
            d_q <= d_d;
            c_q <= c_d;
        end
    end

    assign p.res_valid = p.shift & v_q[STAGES-1];
    assign p.res_data = d_q[STAGES-1];
    assign p.res_chan = c_q[STAGES-1];
    assign p.busy = |v_q;

    property p_pipe_depth;
        @(posedge clk_i) disable iff (!rstn_i)
        (p.push_valid && !p.shift) |=> v_q[0];
    endproperty
    a_pipe_depth: assert property (p_pipe_depth)
        else $error("pipeline did not accept a sample");
endmodule

// ---- rtl/asq_top.sv ----
`timescale 1ns/1ps
module asq_top import asq_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic event_manager_a_trig_i,
    input wire logic event_manager_b_trig_i,
    input wire logic external_conversion_start_i,
    input wire logic [RES_W-1:0] fe_a_i,
    input wire logic [RES_W-1:0] fe_b_i,
    output logic sh_o,
    output logic [CH_W-1:0] chan_a_o,
    output logic [CH_W-1:0] chan_b_o,
    output logic irq_o
);
    localparam int DIV_W = (HALF_DIV > 1) ? $clog2(HALF_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_DIV - 1);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    asq_pipe_if #(.W(RES_W), .CW(CH_W)) pif ();

    asq_pipe u_pipe (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .p(pif.core)
    );

    logic [31:0] converter_control_one_q, ctrl_d;
    logic [INT_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [31:0] rdata_d;
    logic irq_d;
    logic [RES_W-1:0] res_q [NUM_CH];
    logic [RES_W-1:0] res_d [NUM_CH];
    logic [2:0] ext_s_q, ext_s_d;
    logic ext_lvl_q, ext_lvl_d;
    logic upd1_q, upd1_d, upd2_q, upd2_d;
    asq_state_t state_q, state_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [5:0] hcnt_q, hcnt_d;
    logic phase_q, phase_d;
    logic run_q, run_d;
    logic pend_b_q, pend_b_d;
    logic [RES_W-1:0] hold_b_q, hold_b_d;
    logic sh_d;
    logic [CH_W-1:0] chan_a_d, chan_b_d;

    logic sim_mode, cont, ext_rise, sw_start, sw_stop, trig, start_acc, drop;
    logic half_tick, hdone, sample_edge, conv_tick;
    logic [ACQ_W-1:0] acq;
    logic [5:0] target;

    assign sim_mode = converter_control_one_q[MODE_BIT];
    assign cont = converter_control_one_q[CONT_BIT];
    assign acq = converter_control_one_q[ACQ_LSB +: ACQ_W];
    assign sw_start = wr_i & hit(addr_i, CMD_OFS) & wdata_i[CMD_START_BIT];
    assign sw_stop = wr_i & hit(addr_i, CMD_OFS) & wdata_i[CMD_STOP_BIT];
    // The pin level counts only once the two late stages agree.
    assign ext_rise = ext_s_q[1] & ext_s_q[2] & ~ext_lvl_q;
    assign trig = (converter_control_one_q[TEN_LSB] & event_manager_a_trig_i)
        | (converter_control_one_q[TEN_LSB+1] & event_manager_b_trig_i)
        | (converter_control_one_q[TEN_LSB+2] & ext_rise)
        | sw_start;
    // A trigger during a running sequence is dropped, not queued.
    assign start_acc = trig & (state_q == S_IDLE);
    assign drop = trig & (state_q != S_IDLE);
    assign half_tick = (div_q == DIV_LAST);

    always_comb begin
        case (state_q)
            S_DELAY: target = TRIG_HALVES;
            S_SAMPLE: target = 6'({acq, 1'b0}) + SH_BASE_HALVES;
            S_GAP: target = sim_mode ? SIM_GAP_HALVES
                                  : SEQ_GAP_HALVES;
            default: target = 6'h3f;
        endcase
    end

    assign hdone = half_tick & ((hcnt_q + 6'h01) == target);
    assign sample_edge = (state_q == S_SAMPLE) & hdone;
    // The converter clock is realigned to each sampling edge. A tick that
    // lands on a sampling edge still shifts the core, or every result of a
    // running sequence would lag by one converter clock.
    assign conv_tick = half_tick & phase_q;

    // Sequencer.
    always_comb begin
        state_d = state_q;
        hcnt_d = hcnt_q;
        run_d = run_q & ~sw_stop;
        div_d = half_tick ? '0 : div_q + DIV_W'(1);
        phase_d = half_tick ? ~phase_q : phase_q;
        if (start_acc) begin
            state_d = S_DELAY;
            hcnt_d = '0;
            div_d = '0;
            run_d = cont;
        end else if (state_q != S_IDLE && half_tick) begin
            hcnt_d = hdone ? 6'h00 : hcnt_q + 6'h01;
            if (hdone) begin
                case (state_q)
                    S_DELAY: state_d = S_SAMPLE;
                    S_SAMPLE: state_d = S_GAP;
                    S_GAP: state_d = run_d ? S_SAMPLE : S_IDLE;
                    default: state_d = S_IDLE;
                endcase
            end
        end
        if (sample_edge) begin
            phase_d = 1'b0;
        end
        sh_d = (state_d == S_SAMPLE);
    end

    // Channel selection and feeding the core.
    always_comb begin
        chan_a_d = sim_mode ? {1'b0, converter_control_one_q[CHAN_LSB +: 3]}
                         : converter_control_one_q[CHAN_LSB +: CH_W];
        // Only equal-index pairs exist here, so B follows A's index.
        chan_b_d = {1'b1, converter_control_one_q[CHAN_LSB +: 3]};
        pend_b_d = pend_b_q;
        hold_b_d = hold_b_q;
        pif.shift = conv_tick;
        pif.push_valid = 1'b0;
        pif.push_data = fe_a_i;
        pif.push_chan = chan_a_o;
        if (sample_edge) begin
            pif.push_valid = 1'b1;
            pend_b_d = sim_mode;
            hold_b_d = fe_b_i;
        end else if (conv_tick && pend_b_q) begin
            pif.push_valid = 1'b1;
            pif.push_data = hold_b_q;
            pif.push_chan = chan_b_o;
            pend_b_d = 1'b0;
        end
    end

    // Registers, results and the interrupt path.
    always_comb begin
        ctrl_d = converter_control_one_q;
        mask_d = mask_q;
        stat_d = stat_q;
        res_d = res_q;
        rdata_d = '0;
        ext_s_d = {ext_s_q[1:0], external_conversion_start_i};
        ext_lvl_d = (ext_s_q[1] == ext_s_q[2]) ? ext_s_q[2] : ext_lvl_q;
        upd1_d = pif.res_valid;
        upd2_d = upd1_q;
        if (pif.res_valid) begin
            res_d[pif.res_chan] = pif.res_data;
        end
        if (wr_i && hit(addr_i, CTRL1_OFS)) begin
            ctrl_d = wdata_i & CTRL1_MASK;
        end
        if (wr_i && hit(addr_i, MASK_OFS)) begin
            mask_d = wdata_i[INT_W-1:0];
        end
        if (wr_i && hit(addr_i, STAT_OFS)) begin
            stat_d = stat_q & ~wdata_i[INT_W-1:0];
        end
        // Set wins over a clear in the same cycle.
        stat_d[STAT_DONE_BIT] = stat_d[STAT_DONE_BIT] | upd2_q;
        stat_d[STAT_DROP_BIT] = stat_d[STAT_DROP_BIT] | drop;
        if (rd_i) begin
            if (hit(addr_i, CTRL1_OFS)) begin
                rdata_d = converter_control_one_q;
            end else if (hit(addr_i, STAT_OFS)) begin
                rdata_d[INT_W-1:0] = stat_q;
                rdata_d[STAT_BUSY_BIT] = (state_q != S_IDLE) | pend_b_q
                    | pif.busy;
            end else if (hit(addr_i, MASK_OFS)) begin
                rdata_d[INT_W-1:0] = mask_q;
            end else if (addr_i[7:6] == RES_BASE[7:6] && addr_i[1:0] == 2'h0)
            begin
                rdata_d[RES_W-1:0] = res_q[addr_i[5:2]];
            end
        end
        irq_d = |(stat_q & mask_q);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            converter_control_one_q <= CTRL1_RST;
            stat_q <= STAT_RST;
            mask_q <= MASK_RST;
            rdata_o <= '0;
            irq_o <= 1'b0;
            for (int i = 0; i < NUM_CH; i++) begin
                res_q[i] <= '0;
            end
            ext_s_q <= '0;
            ext_lvl_q <= 1'b0;
            upd1_q <= 1'b0;
            upd2_q <= 1'b0;
            state_q <= S_IDLE;
            div_q <= '0;
            hcnt_q <= '0;
            phase_q <= 1'b0;
            run_q <= 1'b0;
            pend_b_q <= 1'b0;
            hold_b_q <= '0;
            sh_o <= 1'b0;
            chan_a_o <= '0;
            chan_b_o <= '0;
        end else begin
            converter_control_one_q <= ctrl_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_o <= rdata_d;
            irq_o <= irq_d;
            res_q <= res_d;
            ext_s_q <= ext_s_d;
            ext_lvl_q <= ext_lvl_d;
            upd1_q <= upd1_d;
            upd2_q <= upd2_d;
            state_q <= state_d;
            div_q <= div_d;
            hcnt_q <= hcnt_d;
            phase_q <= phase_d;
            run_q <= run_d;
            pend_b_q <= pend_b_d;
            hold_b_q <= hold_b_d;
            sh_o <= sh_d;
            chan_a_o <= chan_a_d;
            chan_b_o <= chan_b_d;
        end
    end

    // Helper counters read only by the checks below.
    logic [7:0] hc_q, sh_cnt_q;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hc_q <= '0;
            sh_cnt_q <= '0;
        end else begin
            hc_q <= start_acc ? 8'h00 : (hc_q + {7'h00, ~&hc_q});
            sh_cnt_q <= sh_o ? sh_cnt_q + 8'h01 : 8'h00;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_seq_chan;
        sample_edge && !sim_mode |->
            pif.push_chan == converter_control_one_q[CHAN_LSB +: CH_W];
    endproperty
    a_seq_chan: assert property (p_seq_chan)
        else $error("sequential sample took the wrong channel");

    property p_sim_b_push;
        sample_edge && sim_mode |-> ##8 (pif.push_valid && pif.push_chan[3]);
    endproperty
    a_sim_b_push: assert property (p_sim_b_push)
        else $error("B sample not fed one converter clock later");

    property p_pair;
        sim_mode |=> chan_b_o == {1'b1, chan_a_o[2:0]};
    endproperty
    a_pair: assert property (p_pair)
        else $error("pair select indices differ");

    property p_start;
        start_acc |=> state_q == S_DELAY;
    endproperty
    a_start: assert property (p_start)
        else $error("accepted trigger did not start sequence");

    property p_fall;
        sample_edge |=> $fell(sh_o);
    endproperty
    a_fall: assert property (p_fall)
        else $error("sampling not on sample/hold falling edge");

    property p_sh_width;
        $fell(sh_o) |-> sh_cnt_q == 8'(({4'h0, acq} + 8'h01) * 8'h08);
    endproperty
    a_sh_width: assert property (p_sh_width)
        else $error("sample/hold width wrong");

    property p_trig_delay;
        $rose(sh_o) && $past(state_q) == S_DELAY |-> hc_q == 8'h14;
    endproperty
    a_trig_delay: assert property (p_trig_delay)
        else $error("sampling not 2.5 converter clocks after trigger");

    property p_first_a;
        sample_edge |-> ##32 pif.res_valid;
    endproperty
    a_first_a: assert property (p_first_a)
        else $error("A result not four converter clocks after sampling");

    property p_first_b;
        sample_edge && sim_mode |-> ##40 (pif.res_valid && pif.res_chan[3]);
    endproperty
    a_first_b: assert property (p_first_b)
        else $error("B result not five converter clocks after sampling");

    property p_seq_gap;
        $fell(sh_o) && !sim_mode && run_q |-> ##8 ($rose(sh_o) || !run_q);
    endproperty
    a_seq_gap: assert property (p_seq_gap)
        else $error("sequential sample spacing wrong");

    property p_sim_gap;
        $fell(sh_o) && sim_mode && run_q |-> ##16 ($rose(sh_o) || !run_q);
    endproperty
    a_sim_gap: assert property (p_sim_gap)
        else $error("simultaneous sample spacing wrong");

    property p_flag;
        pif.res_valid |-> ##3 stat_q[STAT_DONE_BIT];
    endproperty
    a_flag: assert property (p_flag)
        else $error("done flag not set three clocks after result");

    c_seq: cover property (sample_edge && !sim_mode);
    c_sim_b: cover property (pif.res_valid && pif.res_chan[3]);
    c_ext: cover property (ext_rise && start_acc);
endmodule

// ---- verif/asq_far_side.sv ----
`timescale 1ns/1ps
module asq_far_side import asq_pkg::*; (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic sh_i,
    input wire logic [CH_W-1:0] chan_a_i,
    input wire logic [CH_W-1:0] chan_b_i,
    output logic evt_a_o,
    output logic evt_b_o,
    output logic ext_o,
    output logic [RES_W-1:0] fe_a_o,
    output logic [RES_W-1:0] fe_b_o
);
    logic sh_q;
    logic [7:0] k_q;

    initial begin
        evt_a_o = 1'b0;
        evt_b_o = 1'b0;
        ext_o = 1'b0;
    end

    // A new value settles only after a sampling edge has gone by, so every
    // result can be traced to the sample count and the channel it came from.
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_q <= 1'b0;
            k_q <= 8'h00;
        end else begin
            sh_q <= sh_i;
            if (sh_q && !sh_i) begin
                k_q <= k_q + 8'h01;
            end
        end
    end

    assign fe_a_o = {chan_a_i, k_q};
    assign fe_b_o = {chan_b_i, ~k_q};

    // The event lines pulse for a single cycle, so they never ask twice.
    task automatic fire(input int src);
        @(posedge clk_i);
        case (src)
            0: evt_a_o <= 1'b1;
            1: evt_b_o <= 1'b1;
            default: ext_o <= 1'b1;
        endcase
        @(posedge clk_i);
        evt_a_o <= 1'b0;
        evt_b_o <= 1'b0;
        // The pin goes through a resync that needs two stages to agree, so
        // it stays up a few cycles; its rising edge still counts only once.
        if (src > 1) begin
            repeat (3) @(posedge clk_i);
        end
        ext_o <= 1'b0;
    endtask
endmodule

// ---- verif/tb_adc_sample_sequencing.sv ----
`timescale 1ns/1ps
module tb_adc_sample_sequencing import asq_pkg::*;;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic evt_a, evt_b, ext_s, sh_o, irq_o;
    logic [RES_W-1:0] fe_a, fe_b;
    logic [CH_W-1:0] chan_a_o, chan_b_o;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int trig_c = 0, rise_c = 0, per_c = 0, fall_c = 0, irq_c = 0;
    int n_fall = 0;
    int n0, src;
    logic sh_p = 1'b0;
    logic irq_p = 1'b0;
    logic [31:0] d;

    asq_top i_asq_top (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .event_manager_a_trig_i(evt_a), .event_manager_b_trig_i(evt_b),
        .external_conversion_start_i(ext_s), .fe_a_i(fe_a), .fe_b_i(fe_b),
        .sh_o(sh_o), .chan_a_o(chan_a_o), .chan_b_o(chan_b_o),
        .irq_o(irq_o));

    asq_far_side i_asq_far_side (.clk_i(clk_i), .rstn_i(rstn_i),
        .sh_i(sh_o), .chan_a_i(chan_a_o), .chan_b_i(chan_b_o),
        .evt_a_o(evt_a), .evt_b_o(evt_b), .ext_o(ext_s),
        .fe_a_o(fe_a), .fe_b_o(fe_b));

    always #2.5 clk_i = ~clk_i;

    // All events are stamped with the values sampled at the same edge, so
    // the differences between stamps are exact cycle counts.
    always @(posedge clk_i) begin
        if (wr_i && addr_i == CMD_OFS && wdata_i[CMD_START_BIT]) trig_c = cyc;
        if (evt_a || evt_b) trig_c = cyc;
        if (sh_o && !sh_p) begin
            per_c = cyc - rise_c;
            rise_c = cyc;
        end
        if (!sh_o && sh_p) begin
            fall_c = cyc;
            n_fall++;
        end
        if (irq_o && !irq_p) irq_c = cyc;
        sh_p = sh_o;
        irq_p = irq_o;
        cyc++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        v = rdata_o;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(v, e);
    endtask

    function automatic logic [31:0] ctl(input logic mode, input logic cont,
        input logic [3:0] acq, input logic [3:0] ch, input logic [2:0] ten);
        return {9'h000, ten, ch, 4'h0, acq, 6'h00, cont, mode};
    endfunction

    function automatic logic [31:0] res(input logic [3:0] ch, input int k);
        return {20'h00000, ch, 8'(k)};
    endfunction

    task automatic wait_idle();
        int i;
        logic [31:0] v;
        repeat (30) @(posedge clk_i);
        for (i = 0; i < 300; i++) begin
            rd(STAT_OFS, v);
            if (v[STAT_BUSY_BIT] === 1'b0) break;
        end
        if (i == 300) errors++;
        repeat (60) @(posedge clk_i);
    endtask

    task automatic wait_falls(input int n);
        int i;
        for (i = 0; i < 3000 && n_fall < n; i++) @(posedge clk_i);
        if (n_fall < n) errors++;
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #300000;
        errors++;
        final_report();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        rchk(CTRL1_OFS, CTRL1_RST);
        rchk(STAT_OFS, 32'h0);
        rchk(MASK_OFS, 32'h0);
        rchk(8'h20, 32'h0);
        wr(CMD_OFS, 32'h0); 
        rchk(CMD_OFS, 32'h0);
        $display("Test reset values done");

        wr(MASK_OFS, 32'h1);
        wr(CTRL1_OFS, ctl(1'b0, 1'b0, 4'h0, 4'h5, 3'h0));
        wr(CMD_OFS, 32'h1);
        wait_idle();
        chk(32'(rise_c - trig_c), 32'd21);
        chk(32'(fall_c - rise_c), 32'd8);
        chk(32'(chan_a_o), 32'h5);
        chk(32'(irq_c - fall_c), 32'd35);
        rchk(RES_BASE + 8'h14, res(4'h5, n_fall - 1));
        chk(32'(irq_o), 32'h1);
        wr(STAT_OFS, 32'h1);
        rchk(STAT_OFS, 32'h0);
        chk(32'(irq_o), 32'h0);
        $display("Test sequential single done");

        wr(CTRL1_OFS, ctl(1'b0, 1'b1, 4'h2, 4'hc, 3'h0));
        n0 = n_fall;
        wr(CMD_OFS, 32'h1);
        wait_falls(n0 + 3);
        chk(32'(fall_c - rise_c), 32'd24);
        chk(32'(per_c), 32'd32);
        wr(CMD_OFS, 32'h1);
        rd(STAT_OFS, d);
        chk(32'(d[STAT_DROP_BIT]), 32'h1);
        wr(CMD_OFS, 32'h2);
        wait_idle();
        rchk(RES_BASE + 8'h30, res(4'hc, n_fall - 1));
        wr(MASK_OFS, 32'h2);
        wr(STAT_OFS, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(32'(irq_o), 32'h1);
        wr(STAT_OFS, 32'h2);
        repeat (3) @(posedge clk_i);
        chk(32'(irq_o), 32'h0);
        wr(MASK_OFS, 32'h1);
        $display("Test sequential continuous done");

        wr(CTRL1_OFS, ctl(1'b1, 1'b0, 4'hf, 4'h3, 3'h0));
        wr(CMD_OFS, 32'h1);
        wait_idle();
        chk(32'(rise_c - trig_c), 32'd21);
        chk(32'(fall_c - rise_c), 32'd128);
        chk(32'(chan_a_o), 32'h3);
        chk(32'(chan_b_o), 32'hb);
        chk(32'(irq_c - fall_c), 32'd35);
        rchk(RES_BASE + 8'h0c, res(4'h3, n_fall - 1));
        rchk(RES_BASE + 8'h2c, res(4'hb, ~(n_fall - 1)));
        wr(STAT_OFS, 32'h3);
        wr(CTRL1_OFS, ctl(1'b1, 1'b1, 4'h0, 4'h7, 3'h0));
        n0 = n_fall;
        wr(CMD_OFS, 32'h1);
        wait_falls(n0 + 3);
        chk(32'(per_c), 32'd24);
        wr(CMD_OFS, 32'h2);
        wait_idle();
        rchk(RES_BASE + 8'h3c, res(4'hf, ~(n_fall - 1)));
        wr(STAT_OFS, 32'h3);
        $display("Test simultaneous done");

        wr(CTRL1_OFS, ctl(1'b0, 1'b0, 4'h1, 4'h9, 3'h7));
        for (src = 0; src < 3; src++) begin
            n0 = n_fall;
            i_asq_far_side.fire(src);
            wait_idle();
            chk(32'(n_fall - n0), 32'd1);
            if (src < 2) chk(32'(rise_c - trig_c), 32'd21);
        end
        rchk(RES_BASE + 8'h24, res(4'h9, n_fall - 1));
        wr(CTRL1_OFS, ctl(1'b0, 1'b0, 4'h1, 4'h9, 3'h0));
        n0 = n_fall;
        i_asq_far_side.fire(0);
        repeat (60) @(posedge clk_i);
        chk(32'(n_fall - n0), 32'd0);
        $display("Test trigger sources done");
        final_report();
    end
endmodule
